// *** adc_regs_params.svh ***
// Register offsets, field positions, masks and reset values of the mode and fast-detect bank.
`ifndef ADC_REGS_PARAMS_SVH
`define ADC_REGS_PARAMS_SVH

`define ADDR_PHASE_STATUS   15'h0129
`define ADDR_SYSREF_COUNT   15'h012a
`define ADDR_SYNC_SELECT    15'h01ff
`define ADDR_APP_SELECT     15'h0200
`define ADDR_DECIM_SELECT   15'h0201
`define ADDR_OFFSET_ADJUST  15'h0228
`define ADDR_PIN_CONTROL    15'h0245
`define ADDR_UPPER_LOW      15'h0247
`define ADDR_UPPER_HIGH     15'h0248
`define ADDR_LOWER_LOW      15'h0249
`define ADDR_LOWER_HIGH     15'h024a
`define ADDR_HOLD_LOW       15'h024b
`define ADDR_HOLD_HIGH      15'h024c
`define ADDR_MON_SYNC       15'h026f
`define ADDR_MON_CONTROL    15'h0270

`define RESET_BYTE          8'h00
`define READ_UNMAPPED       8'h00

`define MASK_SYNC_SELECT    8'h03
`define MASK_APP_SELECT     8'h23
`define MASK_DECIM_SELECT   8'h07
`define MASK_PIN_CONTROL    8'h0d
`define MASK_LIMIT_HIGH     8'h1f
`define MASK_MON_SYNC       8'h03
`define MASK_MON_CONTROL    8'h02

`define BIT_Q_IGNORE        5
`define BIT_PIN_ENABLE      0
`define BIT_FORCE_VALUE     2
`define BIT_FORCE_SELECT    3
`define BIT_PEAK_ENABLE     1
`define BIT_READ_FLAG       15

`define MODE_FULL_BW        2'h0
`define MODE_DDC0_ONLY      2'h1
`define MODE_DDC_BOTH       2'h2
`define DECIM_CODE_1        3'h0
`define DECIM_CODE_2        3'h1
`define DECIM_CODE_4        3'h2
`define DECIM_CODE_8        3'h3
`define PHASE_MASK          8'h0f

`define INSTR_LAST_BIT      5'h0f
`define DATA_FIRST_BIT      5'h10
`define DATA_LAST_BIT       5'h17
`define SAT_POS             14'h1fff
`define SAT_NEG             14'h2000

`endif

// *** adc_regs_pkg.sv ***
// Types shared by the mode and fast-detect register bank.
package adc_regs_pkg;

    typedef enum logic [2:0] {
        PH_INSTR = 3'h1,
        PH_WRITE = 3'h2,
        PH_READ  = 3'h4
    } spi_phase_t;

    typedef enum logic [1:0] {
        MON_SYNC_OFF        = 2'h0,
        MON_SYNC_CONTINUOUS = 2'h1,
        MON_SYNC_ONE_SHOT   = 2'h2,
        MON_SYNC_RESERVED   = 2'h3
    } monitor_sync_t;

    typedef struct packed {
        logic          valid;
        logic [13:0]   data;
    } sample_t;

    typedef struct packed {
        logic          q_ignore;
        logic          full_bandwidth;
        logic          ddc0_enable;
        logic          ddc1_enable;
        logic [3:0]    decimation;
        logic          timestamp_sync;
        logic [12:0]   upper_limit;
        logic [12:0]   lower_limit;
        logic [15:0]   hold_time;
        monitor_sync_t monitor_sync;
        logic          peak_enable;
    } chip_mode_t;

    typedef struct packed {
        logic [1:0]  csb_sync;
        logic [1:0]  sclk_sync;
        logic [1:0]  sdi_sync;
        logic        sclk_prev;
        spi_phase_t  phase;
        logic [4:0]  bit_cnt;
        logic [15:0] shift_in;
        logic [14:0] addr;
        logic [7:0]  tx;
        logic        sdo;
        logic        sdo_oe_n;
        logic [7:0]  phase_status;
        logic [7:0]  sysref_count;
        logic [7:0]  sync_sel;
        logic [7:0]  app_sel;
        logic [7:0]  decim_sel;
        logic [7:0]  offset;
        logic [7:0]  pin_ctrl;
        logic [7:0]  upper_lo;
        logic [7:0]  upper_hi;
        logic [7:0]  lower_lo;
        logic [7:0]  lower_hi;
        logic [7:0]  hold_lo;
        logic [7:0]  hold_hi;
        logic [7:0]  mon_sync;
        logic [7:0]  mon_ctrl;
        logic        over_raw;
        logic [15:0] hold_cnt;
        logic        pin;
        sample_t     sample_out;
        chip_mode_t  mode;
    } bank_state_t;

endpackage

// *** adc_chip_mode_fast_detect_regs.sv ***
// Serial-port register bank for chip mode, offset and fast overrange detection.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"

module adc_chip_mode_fast_detect_regs
    import adc_regs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic       spi_csb_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sdio_in,
    output logic            spi_sdio_out,
    output logic            spi_sdio_oe_n,
    input  wire logic       sysref_captured,
    input  wire logic [3:0] sysref_lag,
    input  wire sample_t    sample_in,
    output sample_t         sample_adjusted,
    output logic            overrange_indicator_pin,
    output chip_mode_t      chip_mode
);

    bank_state_t st;
    bank_state_t next_st;

    function automatic logic [7:0] read_reg(input logic [14:0] a, input bank_state_t s);
        logic [7:0] d;
        d = `READ_UNMAPPED;
        case (a)
            `ADDR_PHASE_STATUS:  d = s.phase_status;
            `ADDR_SYSREF_COUNT:  d = s.sysref_count;
            `ADDR_SYNC_SELECT:   d = s.sync_sel;
            `ADDR_APP_SELECT:    d = s.app_sel;
            `ADDR_DECIM_SELECT:  d = s.decim_sel;
            `ADDR_OFFSET_ADJUST: d = s.offset;
            `ADDR_PIN_CONTROL:   d = s.pin_ctrl;
            `ADDR_UPPER_LOW:     d = s.upper_lo;
            `ADDR_UPPER_HIGH:    d = s.upper_hi;
            `ADDR_LOWER_LOW:     d = s.lower_lo;
            `ADDR_LOWER_HIGH:    d = s.lower_hi;
            `ADDR_HOLD_LOW:      d = s.hold_lo;
            `ADDR_HOLD_HIGH:     d = s.hold_hi;
            `ADDR_MON_SYNC:      d = s.mon_sync;
            `ADDR_MON_CONTROL:   d = s.mon_ctrl;
            default:             d = `READ_UNMAPPED;
        endcase
        return d;
    endfunction

    // Codes beyond divide-by-8 are not defined; they fall back to full rate.
    function automatic logic [3:0] decim_factor(input logic [2:0] code);
        logic [3:0] f;
        case (code)
            `DECIM_CODE_2: f = 4'h2;
            `DECIM_CODE_4: f = 4'h4;
            `DECIM_CODE_8: f = 4'h8;
            default:       f = 4'h1;
        endcase
        return f;
    endfunction

    logic [14:0] offset_sum;
    logic [13:0] sample_mag;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [15:0] shifted;

    always_comb begin
        next_st = st;
        offset_sum = 15'h0000;
        sample_mag = 14'h0000;
        shifted = {st.shift_in[14:0], st.sdi_sync[1]};
        sclk_rise = st.sclk_sync[1] & ~st.sclk_prev;
        sclk_fall = ~st.sclk_sync[1] & st.sclk_prev;

        // Pins pass two flops; only the second stage feeds logic.
        next_st.csb_sync  = {st.csb_sync[0], spi_csb_n};
        next_st.sclk_sync = {st.sclk_sync[0], spi_sclk};
        next_st.sdi_sync  = {st.sdi_sync[0], spi_sdio_in};
        next_st.sclk_prev = st.sclk_sync[1];

        // Status registers track the capture logic on every cycle with ce high.
        next_st.phase_status = {4'h0, sysref_lag} & `PHASE_MASK;
        if (sysref_captured) begin
            next_st.sysref_count = st.sysref_count + 8'h01;
        end

        if (st.csb_sync[1]) begin
            // Deselect aborts any partial byte and releases the data line.
            next_st.phase    = PH_INSTR;
            next_st.bit_cnt  = 5'h00;
            next_st.sdo_oe_n = 1'b1;
        end else begin
            if (sclk_rise) begin
                next_st.shift_in = shifted;
                next_st.bit_cnt  = st.bit_cnt + 5'h01;
                case (st.phase)
                    PH_INSTR: begin
                        if (st.bit_cnt == `INSTR_LAST_BIT) begin
                            next_st.addr = shifted[14:0];
                            if (shifted[`BIT_READ_FLAG]) begin
                                next_st.phase    = PH_READ;
                                next_st.tx       = read_reg(shifted[14:0], st);
                                next_st.sdo      = next_st.tx[7];
                                next_st.sdo_oe_n = 1'b0;
                            end else begin
                                next_st.phase = PH_WRITE;
                            end
                        end
                    end
                    PH_WRITE: begin
                        if (st.bit_cnt == `DATA_LAST_BIT) begin
                            // Streaming: each further byte goes to the next address.
                            next_st.bit_cnt = `DATA_FIRST_BIT;
                            next_st.addr    = st.addr + 15'h0001;
                            case (st.addr)
                                `ADDR_SYNC_SELECT:   next_st.sync_sel = shifted[7:0] & `MASK_SYNC_SELECT;
                                `ADDR_APP_SELECT:    next_st.app_sel = shifted[7:0] & `MASK_APP_SELECT;
                                `ADDR_DECIM_SELECT:  next_st.decim_sel = shifted[7:0] & `MASK_DECIM_SELECT;
                                `ADDR_OFFSET_ADJUST: next_st.offset = shifted[7:0];
                                `ADDR_PIN_CONTROL:   next_st.pin_ctrl = shifted[7:0] & `MASK_PIN_CONTROL;
                                `ADDR_UPPER_LOW:     next_st.upper_lo = shifted[7:0];
                                `ADDR_UPPER_HIGH:    next_st.upper_hi = shifted[7:0] & `MASK_LIMIT_HIGH;
                                `ADDR_LOWER_LOW:     next_st.lower_lo = shifted[7:0];
                                `ADDR_LOWER_HIGH:    next_st.lower_hi = shifted[7:0] & `MASK_LIMIT_HIGH;
                                `ADDR_HOLD_LOW:      next_st.hold_lo = shifted[7:0];
                                `ADDR_HOLD_HIGH:     next_st.hold_hi = shifted[7:0];
                                `ADDR_MON_SYNC:      next_st.mon_sync = shifted[7:0] & `MASK_MON_SYNC;
                                `ADDR_MON_CONTROL:   next_st.mon_ctrl = shifted[7:0] & `MASK_MON_CONTROL;
                                default:             next_st.addr = st.addr + 15'h0001;
                            endcase
                        end
                    end
                    PH_READ: begin
                        if (st.bit_cnt == `DATA_LAST_BIT) begin
                            next_st.bit_cnt = `DATA_FIRST_BIT;
                            next_st.addr    = st.addr + 15'h0001;
                            next_st.tx      = read_reg(st.addr + 15'h0001, st);
                        end
                    end
                    default: begin
                        next_st.phase = PH_INSTR;
                    end
                endcase
            end
            // Read data changes on the falling edge so the master samples it stable.
            if (sclk_fall && st.phase == PH_READ) begin
                if (st.bit_cnt != `DATA_FIRST_BIT) begin
                    next_st.tx = {st.tx[6:0], 1'b0};
                end
                next_st.sdo = (st.bit_cnt != `DATA_FIRST_BIT) ? st.tx[6] : st.tx[7];
            end
        end

        // Offset is added with saturation so a large offset cannot wrap the code.
        next_st.sample_out.valid = sample_in.valid;
        offset_sum = {sample_in.data[13], sample_in.data}
                   + {{7{st.offset[7]}}, st.offset};
        if (offset_sum[14] != offset_sum[13]) begin
            next_st.sample_out.data = offset_sum[14] ? `SAT_NEG : `SAT_POS;
        end else begin
            next_st.sample_out.data = offset_sum[13:0];
        end

        // Hysteresis detector: set above upper, clear after dwell below lower.
        sample_mag = sample_in.data[13] ? (14'h0000 - sample_in.data) : sample_in.data;
        if (sample_in.valid) begin
            if (sample_mag > {1'b0, st.mode.upper_limit}) begin
                next_st.over_raw = 1'b1;
                next_st.hold_cnt = 16'h0000;
            end else if (st.over_raw && sample_mag < {1'b0, st.mode.lower_limit}) begin
                if (st.hold_cnt >= st.mode.hold_time) begin
                    next_st.over_raw = 1'b0;
                    next_st.hold_cnt = 16'h0000;
                end else begin
                    next_st.hold_cnt = st.hold_cnt + 16'h0001;
                end
            end else begin
                next_st.hold_cnt = 16'h0000;
            end
        end

        if (!st.pin_ctrl[`BIT_PIN_ENABLE]) begin
            next_st.pin = 1'b0;
        end else if (st.pin_ctrl[`BIT_FORCE_SELECT]) begin
            next_st.pin = st.pin_ctrl[`BIT_FORCE_VALUE];
        end else begin
            next_st.pin = st.over_raw;
        end

        // Decoded mode settles one cycle after the register write.
        next_st.mode.q_ignore       = st.app_sel[`BIT_Q_IGNORE];
        next_st.mode.full_bandwidth = (st.app_sel[1:0] == `MODE_FULL_BW);
        next_st.mode.ddc0_enable    = (st.app_sel[1:0] == `MODE_DDC0_ONLY)
                                    || (st.app_sel[1:0] == `MODE_DDC_BOTH);
        next_st.mode.ddc1_enable    = (st.app_sel[1:0] == `MODE_DDC_BOTH);
        next_st.mode.decimation     = decim_factor(st.decim_sel[2:0]);
        next_st.mode.timestamp_sync = st.sync_sel[0];
        next_st.mode.upper_limit    = {st.upper_hi[4:0], st.upper_lo};
        next_st.mode.lower_limit    = {st.lower_hi[4:0], st.lower_lo};
        next_st.mode.hold_time      = {st.hold_hi, st.hold_lo};
        next_st.mode.monitor_sync   = monitor_sync_t'(st.mon_sync[1:0]);
        next_st.mode.peak_enable    = st.mon_ctrl[`BIT_PEAK_ENABLE];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st                   <= '0;
            st.csb_sync          <= 2'h3;
            st.phase             <= PH_INSTR;
            st.sdo_oe_n          <= 1'b1;
            st.pin_ctrl          <= `RESET_BYTE;
            st.mon_ctrl          <= `RESET_BYTE;
            st.mode.full_bandwidth <= 1'b1;
            st.mode.decimation   <= 4'h1;
            st.mode.monitor_sync <= MON_SYNC_OFF;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign spi_sdio_out            = st.sdo;
    assign spi_sdio_oe_n           = st.sdo_oe_n;
    assign sample_adjusted         = st.sample_out;
    assign overrange_indicator_pin = st.pin;
    assign chip_mode               = st.mode;

endmodule // adc_chip_mode_fast_detect_regs

`default_nettype wire

// *** adc_regs_monitor.sv ***
// Port checker for the chip mode and fast-detect register bank.
`timescale 1ns/1ps
`default_nettype none
module adc_regs_monitor
    import adc_regs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic       spi_csb_n,
    input  wire logic       spi_sdio_oe_n,
    input  wire sample_t    sample_in,
    input  wire sample_t    sample_adjusted,
    input  wire logic       overrange_indicator_pin,
    input  wire chip_mode_t chip_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Four idle cycles cover the two-flop chip-select synchroniser plus the registered output enable.
    sequence s_idle; (spi_csb_n && ce) [*4]; endsequence
    sequence s_quiet; (spi_csb_n && ce) [*8]; endsequence
    property p_reset_out;
        $fell(reset) |-> chip_mode.full_bandwidth && chip_mode.decimation == 4'h1
            && spi_sdio_oe_n && !overrange_indicator_pin;
    endproperty
    property p_oe_idle; s_idle |-> spi_sdio_oe_n; endproperty
    property p_oe_fall; $fell(spi_sdio_oe_n) |-> !$past(spi_csb_n, 2); endproperty
    property p_mode_hold; s_quiet |-> $stable(chip_mode); endproperty
    property p_decim; $onehot(chip_mode.decimation); endproperty
    property p_ddc; chip_mode.ddc1_enable |-> chip_mode.ddc0_enable; endproperty
    property p_full; chip_mode.full_bandwidth |-> !chip_mode.ddc0_enable; endproperty
    property p_valid; ce |=> sample_adjusted.valid == $past(sample_in.valid); endproperty
    a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
    a_oe_idle: assert property (p_oe_idle) else $error("sdio driven while idle");
    a_oe_fall: assert property (p_oe_fall) else $error("sdio driven unselected");
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved while idle");
    a_decim: assert property (p_decim) else $error("decimation not one-hot");
    a_ddc: assert property (p_ddc) else $error("second converter alone");
    a_full: assert property (p_full) else $error("full band with converter");
    a_valid: assert property (p_valid) else $error("sample valid not delayed");
endmodule // adc_regs_monitor

bind adc_chip_mode_fast_detect_regs adc_regs_monitor i_mon (.ref_clk(ref_clk),
    .reset(reset), .ce(ce), .spi_csb_n(spi_csb_n), .spi_sdio_oe_n(spi_sdio_oe_n),
    .sample_in(sample_in), .sample_adjusted(sample_adjusted),
    .overrange_indicator_pin(overrange_indicator_pin), .chip_mode(chip_mode));
`default_nettype wire

// *** adc_chip_mode_fast_detect_regs_tb.sv ***
// Self-checking bench for the chip mode and fast-detect register bank.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"
module adc_chip_mode_fast_detect_regs_tb import adc_regs_pkg::*;;
    logic        ref_clk = 0, reset = 1, ce = 1, csb_n = 1, sclk = 0, tb_sdio = 0, srf = 0;
    logic        sdo, oe_n, pin;
    logic [3:0]  lag = 4'h0;
    logic [7:0]  rd, v, o;
    logic [13:0] d;
    sample_t     s_in = '0;
    sample_t     s_out;
    chip_mode_t  mode;
    int          err_total = 0, check_count = 0, n;
    logic [14:0] ra [13] = '{15'h1ff, 15'h200, 15'h201, 15'h228, 15'h245, 15'h247, 15'h248,
                            15'h249, 15'h24a, 15'h24b, 15'h24c, 15'h26f, 15'h270};
    logic [7:0]  rm [13] = '{8'h03, 8'h23, 8'h07, 8'hff, 8'h0d, 8'hff, 8'h1f, 8'hff, 8'h1f,
                            8'hff, 8'hff, 8'h03, 8'h02};
    // The device owns the wire only while its enable is low.
    wire         sdio = oe_n ? tb_sdio : sdo;

    adc_chip_mode_fast_detect_regs i_dut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
        .spi_csb_n(csb_n), .spi_sclk(sclk), .spi_sdio_in(sdio), .spi_sdio_out(sdo),
        .spi_sdio_oe_n(oe_n), .sysref_captured(srf), .sysref_lag(lag), .sample_in(s_in),
        .sample_adjusted(s_out), .overrange_indicator_pin(pin), .chip_mode(mode));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge ref_clk);
    endtask

    // Each serial clock phase lasts four cycles, twice what the two-flop pin synchroniser needs.
    task automatic spi(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] f;
        f = {ins, wd};
        csb_n = 0;
        cyc(4);
        for (int i = 23; i >= 0; i--) begin
            tb_sdio = (i < 8 && ins[15]) ? ~tb_sdio : f[i];
            cyc(4);
            if (i < 8)
                q[i] = sdio;
            sclk = 1;
            cyc(4);
            sclk = 0;
        end
        cyc(6);
        csb_n = 1;
        tb_sdio = ~tb_sdio;
        cyc(6);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] wd);
        logic [7:0] q;
        spi({1'b0, a}, wd, q);
    endtask

    task automatic rdc(input logic [14:0] a, input logic [7:0] e);
        spi({1'b1, a}, 8'h00, rd);
        chk($sformatf("register %h", a), e, rd);
    endtask

    function automatic logic [13:0] adj(input logic [13:0] x, input logic [7:0] off);
        int s;
        s = $signed(x) + $signed(off);
        return s > 8191 ? `SAT_POS : s < -8192 ? `SAT_NEG : s[13:0];
    endfunction

    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        v = $urandom(5217);
        cyc(5);
        reset = 0;
        cyc(3);
        rdc(15'h129, 8'h00);
        rdc(15'h12a, 8'h00);
        for (int i = 0; i < 13; i++)
            rdc(ra[i], 8'h00);
        for (int i = 0; i < 13; i++) begin
            v = $urandom;
            wr(ra[i], v);
            rdc(ra[i], v & rm[i]);
        end
        wr(15'h100, 8'h5a);
        rdc(15'h100, `READ_UNMAPPED);
        wr(15'h12a, 8'h55);
        rdc(15'h12a, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(15'h200, {2'h0, k[2], 3'h0, k[1:0]});
            chk("q_ignore", k[2], mode.q_ignore);
            chk("app mode", k[1:0] == 0 ? 3'h4 : k[1:0] == 1 ? 3'h2 : k[1:0] == 2 ? 3'h3 : 3'h0,
                {mode.full_bandwidth, mode.ddc0_enable, mode.ddc1_enable});
            wr(15'h201, k[7:0]);
            chk("decimation", k == 1 ? 4'h2 : k == 2 ? 4'h4 : k == 3 ? 4'h8 : 4'h1,
                mode.decimation);
            wr(15'h26f, {6'h0, k[1:0]});
            chk("monitor sync", k[1:0], mode.monitor_sync);
            wr(15'h270, {6'h0, k[0], 1'b0});
            chk("peak", k[0], mode.peak_enable);
        end
        v = $urandom;
        wr(15'h24b, v);
        wr(15'h24c, ~v);
        chk("hold time", {~v, v}, mode.hold_time);
        lag = 4'($urandom);
        n = 250 + $urandom % 20;
        repeat (n) begin
            srf = 1;
            cyc(1);
            srf = 0;
            cyc(1);
        end
        // With the enable low a capture pulse must not reach the counter.
        ce = 0;
        srf = 1;
        cyc(2);
        srf = 0;
        ce = 1;
        cyc(1);
        rdc(15'h12a, n[7:0]);
        rdc(15'h129, {4'h0, lag});
        for (int i = 0; i < 16; i++) begin
            o = i == 0 ? 8'h7f : i == 1 ? 8'h80 : 8'($urandom);
            d = i == 0 ? 14'h1fff : i == 1 ? 14'h2000 : 14'($urandom);
            wr(15'h228, o);
            s_in = '{valid: 1'b1, data: d};
            cyc(1);
            s_in.valid = 0;
            chk("adjusted", adj(d, o), s_out.data);
        end
        wr(15'h245, 8'h0c);
        chk("pin off", 1'b0, pin);
        wr(15'h245, 8'h0d);
        chk("pin forced 1", 1'b1, pin);
        wr(15'h245, 8'h09);
        chk("pin forced 0", 1'b0, pin);
        for (int i = 5; i < 11; i++)
            wr(ra[i], i == 5 ? 8'h64 : i == 7 ? 8'h32 : i == 9 ? 8'h03 : 8'h00);
        wr(15'h245, 8'h01);
        // A large negative sample must trip the detector through its magnitude.
        s_in = '{valid: 1'b1, data: 14'h3f38};
        cyc(1);
        s_in = '{valid: 1'b1, data: 14'h000a};
        cyc(1);
        s_in.valid = 0;
        cyc(2);
        chk("pin set", 1'b1, pin);
        s_in.valid = 1;
        cyc(4);
        s_in.valid = 0;
        cyc(2);
        chk("pin cleared", 1'b0, pin);
        report_and_stop();
    end
endmodule // adc_chip_mode_fast_detect_regs_tb
`default_nettype wire
